// [hw/scmb_defs.vh]
`ifndef SCMB_DEFS_VH
`define SCMB_DEFS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SCMB_OFS_PARAM_WRITE_DATA 8'h0A
`define SCMB_OFS_COMMAND_CODE 8'h0B
`define SCMB_OFS_PARAM_READBACK 8'h10
`define SCMB_OFS_COMMAND_STATUS 8'h11
// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define SCMB_STATUS_RST 8'h2F
`define SCMB_STATUS_ERR_BIT 4
`define SCMB_DATA_RST 8'h00
// default slave address, arbitrary neutral value
`define SCMB_I2C_ADDR_RST 7'h2A
// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define SCMB_CMD_COUNTER_CLEAR 8'h00
`define SCMB_CMD_SOFT_RESET 8'h01
`define SCMB_CMD_NEW_ADDR 8'h02
`define SCMB_CMD_FORCE 8'h11
`define SCMB_CMD_PAUSE 8'h12
`define SCMB_CMD_START 8'h13
`define SCMB_CMD_READ_BASE 2'h1
`define SCMB_CMD_WRITE_BASE 2'h2
// ---------------------------------------------------------------
// parameter table
// ---------------------------------------------------------------
`define SCMB_PARAM_ENTRIES 64
`define SCMB_PARAM_LAST 6'h2D
`define SCMB_LOC_I2C_ADDR 6'h00
`define SCMB_LOC_CHANNEL_SELECT_LIST 6'h01
`endif

// [hw/scmb_mailbox.v]
`timescale 1ns/1ps
`include "scmb_defs.vh"

// Overview of operation
// - successful commands except counter clear and soft reset bump the 4-bit counter
// - command 0x40|loc reads a parameter, 0x80|loc writes one
// - parameter location is the six low bits of the command byte
// - parameter write stores data byte and mirrors it into readback
// - parameter read places the table byte into readback at 0x10
// - register pointer auto-increments within one bus write
// - force, pause, start act on channel list set beforehand
// - counter clear zeroes counter and error flag
// - soft reset restores every parameter and bus register to defaults
// - out-of-table location sets error instead of counting
// - address change adopts low seven bits of address parameter until reset
module scmb_mailbox (
   input wire clk_in,
   input wire resetn_in,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_out,
   output reg [2:0] meas_cmd_out,
   output reg [7:0] channel_select_list_out
);

   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_ACKA = 7'h04;
   localparam [6:0] ST_WR = 7'h08;
   localparam [6:0] ST_ACKW = 7'h10;
   localparam [6:0] ST_RD = 7'h20;
   localparam [6:0] ST_ACKR = 7'h40;

   // ---------------------------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------------------------
   reg scl_s1_r, scl_s2_r, scl_d_r;
   reg sda_s1_r, sda_s2_r, sda_d_r;

   // two flops before use; third stage only for edge finding
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_d_r <= sda_s2_r;
      end
   end

   wire scl_rise = scl_s2_r & ~scl_d_r;
   wire scl_fall = ~scl_s2_r & scl_d_r;
   wire bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire bus_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg [6:0] state_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] ptr_r;
   reg first_r;
   reg read_dir_r;
   reg nack_r;
   reg [6:0] slave_addr_r;
   reg [7:0] param_write_data_r;
   reg [7:0] command_code_r;
   reg [7:0] param_readback_r;
   reg [7:0] command_status_r;
   reg cmd_go_r;
   reg soft_rst_r;
   reg [7:0] param_r [0:`SCMB_PARAM_ENTRIES-1];

   // ---------------------------------------------------------------
   // register read mux
   // ---------------------------------------------------------------
   reg [7:0] rd_data;

   // unmapped offsets read as zero
   always @* begin
      case (ptr_r)
         `SCMB_OFS_PARAM_WRITE_DATA: rd_data = param_write_data_r;
         `SCMB_OFS_COMMAND_CODE: rd_data = command_code_r;
         `SCMB_OFS_PARAM_READBACK: rd_data = param_readback_r;
         `SCMB_OFS_COMMAND_STATUS: rd_data = command_status_r;
         default: rd_data = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // serial slave
   // ---------------------------------------------------------------
   wire byte_done = scl_fall & (bit_cnt_r == 4'h8);
   wire host_wr = (state_r == ST_WR) & byte_done & ~first_r;
   wire [7:0] next_byte = shift_r;

   // data and command registers are written from the bus; soft reset wins
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         param_write_data_r <= `SCMB_DATA_RST;
         command_code_r <= `SCMB_DATA_RST;
         cmd_go_r <= 1'b0;
      end else if (soft_rst_r) begin
         param_write_data_r <= `SCMB_DATA_RST;
         command_code_r <= `SCMB_DATA_RST;
         cmd_go_r <= 1'b0;
      end else begin
         cmd_go_r <= host_wr & (ptr_r == `SCMB_OFS_COMMAND_CODE);
         if (host_wr && ptr_r == `SCMB_OFS_PARAM_WRITE_DATA)
            param_write_data_r <= next_byte;
         if (host_wr && ptr_r == `SCMB_OFS_COMMAND_CODE)
            command_code_r <= next_byte;
      end
   end

   // bus state machine; ack and read data drive low only (open drain)
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         first_r <= 1'b0;
         read_dir_r <= 1'b0;
         nack_r <= 1'b0;
         sda_out <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (soft_rst_r) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         ptr_r <= 8'h00;
         sda_oe_out <= 1'b0;
      end else if (bus_start) begin
         state_r <= ST_ADDR;
         bit_cnt_r <= 4'h0;
         sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
         state_r <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               sda_oe_out <= 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s2_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (byte_done) begin
                  // only our own (possibly renamed) address is answered
                  if (shift_r[7:1] == slave_addr_r) begin
                     state_r <= ST_ACKA;
                     read_dir_r <= shift_r[0];
                     sda_oe_out <= 1'b1;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_ACKA: begin
               if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (read_dir_r) begin
                     state_r <= ST_RD;
                     shift_r <= {rd_data[6:0], 1'b0};
                     sda_oe_out <= ~rd_data[7];
                     ptr_r <= ptr_r + 8'h01;
                  end else begin
                     state_r <= ST_WR;
                     first_r <= 1'b1;
                     sda_oe_out <= 1'b0;
                  end
               end
            end
            ST_WR: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s2_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (byte_done) begin
                  state_r <= ST_ACKW;
                  sda_oe_out <= 1'b1;
                  first_r <= 1'b0;
                  // first byte sets the pointer, later bytes advance it
                  if (first_r)
                     ptr_r <= shift_r;
                  else
                     ptr_r <= ptr_r + 8'h01;
               end
            end
            ST_ACKW: begin
               if (scl_fall) begin
                  state_r <= ST_WR;
                  bit_cnt_r <= 4'h0;
                  sda_oe_out <= 1'b0;
               end
            end
            ST_RD: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (byte_done) begin
                  state_r <= ST_ACKR;
                  sda_oe_out <= 1'b0;
               end else if (scl_fall) begin
                  sda_oe_out <= ~shift_r[7];
                  shift_r <= {shift_r[6:0], 1'b0};
               end
            end
            ST_ACKR: begin
               if (scl_rise) begin
                  nack_r <= sda_s2_r;
               end else if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (nack_r) begin
                     state_r <= ST_IDLE;
                  end else begin
                     // a continued read walks on through the map
                     state_r <= ST_RD;
                     shift_r <= {rd_data[6:0], 1'b0};
                     sda_oe_out <= ~rd_data[7];
                     ptr_r <= ptr_r + 8'h01;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
               sda_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   wire [5:0] loc = command_code_r[5:0];
   wire is_read = command_code_r[7:6] == `SCMB_CMD_READ_BASE;
   wire is_write = command_code_r[7:6] == `SCMB_CMD_WRITE_BASE;
   wire loc_bad = loc > `SCMB_PARAM_LAST;
   wire is_clear = command_code_r == `SCMB_CMD_COUNTER_CLEAR;
   wire is_soft = command_code_r == `SCMB_CMD_SOFT_RESET;
   wire is_addr = command_code_r == `SCMB_CMD_NEW_ADDR;
   wire is_force = command_code_r == `SCMB_CMD_FORCE;
   wire is_pause = command_code_r == `SCMB_CMD_PAUSE;
   wire is_start = command_code_r == `SCMB_CMD_START;
   wire known = is_read | is_write | is_clear | is_soft | is_addr | is_force | is_pause | is_start;
   wire cmd_fail = ~known | ((is_read | is_write) & loc_bad);
   wire do_write = cmd_go_r & is_write & ~loc_bad;

   // parameter table, one entry per generate step
   genvar gi;
   generate
      for (gi = 0; gi < `SCMB_PARAM_ENTRIES; gi = gi + 1) begin : g_param
         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in)
               param_r[gi] <= `SCMB_DATA_RST;
            else if (soft_rst_r)
               param_r[gi] <= `SCMB_DATA_RST;
            else if (do_write && loc == gi)
               param_r[gi] <= param_write_data_r;
         end
      end
   endgenerate

   // executor: one command per write, readback and counter move on one edge
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         param_readback_r <= `SCMB_DATA_RST;
         command_status_r <= `SCMB_STATUS_RST;
         slave_addr_r <= `SCMB_I2C_ADDR_RST;
         soft_rst_r <= 1'b0;
         meas_cmd_out <= 3'h0;
         channel_select_list_out <= 8'h00;
      end else if (soft_rst_r) begin
         param_readback_r <= `SCMB_DATA_RST;
         command_status_r <= `SCMB_STATUS_RST;
         slave_addr_r <= `SCMB_I2C_ADDR_RST;
         soft_rst_r <= 1'b0;
         meas_cmd_out <= 3'h0;
         channel_select_list_out <= 8'h00;
      end else begin
         channel_select_list_out <= param_r[`SCMB_LOC_CHANNEL_SELECT_LIST];
         meas_cmd_out <= 3'h0;
         if (cmd_go_r) begin
            if (is_clear) begin
               command_status_r[3:0] <= 4'h0;
               command_status_r[`SCMB_STATUS_ERR_BIT] <= 1'b0;
            end else if (is_soft) begin
               soft_rst_r <= 1'b1;
            end else if (cmd_fail) begin
               command_status_r[`SCMB_STATUS_ERR_BIT] <= 1'b1;
            end else begin
               // counter wraps naturally in four bits
               command_status_r[3:0] <= command_status_r[3:0] + 4'h1;
               if (is_write)
                  param_readback_r <= param_write_data_r;
               if (is_read)
                  param_readback_r <= param_r[loc];
               if (is_addr)
                  slave_addr_r <= param_r[`SCMB_LOC_I2C_ADDR][6:0];
               // pulses to the measurement engine, which reads the channel list
               meas_cmd_out <= {is_start, is_pause, is_force};
            end
         end
      end
   end

endmodule

// [test/scmb_mailbox_monitor.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker for the command mailbox
// ---------------------------------------------------------------
module scmb_mailbox_monitor (
   input wire clk_in,
   input wire resetn_in,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_out,
   input wire [2:0] meas_cmd_out,
   input wire [7:0] channel_select_list_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   // a measurement pulse is one cycle, then quiet
   sequence s_pulse_end;
      ##1 (meas_cmd_out == 3'h0);
   endsequence
   // the command byte is acked around the cycle it executes
   sequence s_ack_near;
      ##[0:6] sda_oe_out;
   endsequence
   a_drive_value_low: assert property (sda_out == 1'b0)
      else $error("sda value not low");
   a_meas_one_hot: assert property ($onehot0(meas_cmd_out))
      else $error("two measurement commands at once");
   a_meas_single_cycle: assert property ((|meas_cmd_out) |-> s_pulse_end)
      else $error("measurement pulse too long");
   a_meas_on_ack: assert property ((|meas_cmd_out) |-> s_ack_near)
      else $error("measurement pulse without command byte");
   a_ack_rise_low: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("sda pulled while scl high");
   a_ack_fall_low: assert property ($fell(sda_oe_out) |-> !scl_in)
      else $error("sda released while scl high");
   a_sda_steady_high: assert property ((scl_in && $past(scl_in)) |-> $stable(sda_oe_out))
      else $error("sda moved during scl high");
   a_reset_outputs_quiet: assert property ($rose(resetn_in) |-> !sda_oe_out && meas_cmd_out == 3'h0
      && channel_select_list_out == 8'h00)
      else $error("outputs not at reset value");
   c_meas_seen: cover property (|meas_cmd_out);
endmodule

bind scmb_mailbox scmb_mailbox_monitor u_mon (
   .clk_in(clk_in),
   .resetn_in(resetn_in),
   .scl_in(scl_in),
   .sda_in(sda_in),
   .sda_out(sda_out),
   .sda_oe_out(sda_oe_out),
   .meas_cmd_out(meas_cmd_out),
   .channel_select_list_out(channel_select_list_out)
);

// [test/scmb_host.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host bus master model
// ---------------------------------------------------------------
module scmb_host (
   input wire clk_in,
   input wire sda_in,
   output reg scl_out,
   output reg sda_low_out
);
   // idle bus: clock high and data released
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // low phase 8 and high phase 5 clocks, close to a 64 ns link period
   task hp(input integer n);
      repeat (n) @(posedge clk_in);
   endtask
   // one bit from just after scl falls; data moves only while scl is low
   task bitx(input o, output i);
      begin
         hp(3);
         sda_low_out <= ~o;
         hp(5);
         scl_out <= 1'b1;
         hp(3);
         i = sda_in;
         hp(2);
         scl_out <= 1'b0;
      end
   endtask
   // eight bits then the ack slot, which the host always leaves released
   task bytex(input [7:0] o, output [7:0] i, output ack);
      integer k;
      reg n;
      begin
         for (k = 7; k >= 0; k = k - 1) begin
            bitx(o[k], n);
            i[k] = n;
         end
         bitx(1'b1, n);
         ack = ~n;
      end
   endtask
   task start;
      begin
         hp(3);
         sda_low_out <= 1'b1;
         hp(5);
         scl_out <= 1'b0;
      end
   endtask
   task stop;
      begin
         hp(3);
         sda_low_out <= 1'b1;
         hp(5);
         scl_out <= 1'b1;
         hp(5);
         sda_low_out <= 1'b0;
         hp(8);
      end
   endtask
   // pointer then up to two data bytes in one transaction
   task wr(input [6:0] a, input [7:0] p, input [7:0] d0, input [7:0] d1, input integer n, output ok);
      reg [7:0] x;
      reg k0, k1, k2, k3;
      begin
         k2 = 1'b1;
         k3 = 1'b1;
         start;
         bytex({a, 1'b0}, x, k0);
         bytex(p, x, k1);
         if (n > 0) bytex(d0, x, k2);
         if (n > 1) bytex(d1, x, k3);
         stop;
         ok = k0 & k1 & k2 & k3;
      end
   endtask
   // each read is a transaction of its own
   task rd(input [6:0] a, input [7:0] p, output [7:0] d, output ok);
      reg [7:0] x;
      reg k0, k1, k2;
      begin
         wr(a, p, 8'h00, 8'h00, 0, k0);
         start;
         bytex({a, 1'b1}, x, k1);
         bytex(8'hFF, d, k2);
         stop;
         ok = k0 & k1;
      end
   endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   reg clk_in = 1'b0;
   reg resetn_in = 1'b0;
   reg [6:0] adr = 7'h2A;
   reg [2:0] meas_seen = 3'h0;
   reg [7:0] v;
   reg ok;
   integer error_cnt = 0;
   integer compares = 0;
   integer i;
   wire scl_w;
   wire sda_low;
   wire sda_oe;
   wire [2:0] meas;
   wire [7:0] chan;
   // open-drain data line with pull-up: low while either side pulls
   wire sda_w = ~(sda_low | sda_oe);
   always #2.5 clk_in = ~clk_in;
   scmb_mailbox dut (.clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_w), .sda_in(sda_w),
      .sda_out(), .sda_oe_out(sda_oe), .meas_cmd_out(meas), .channel_select_list_out(chan));
   scmb_host host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_w), .sda_low_out(sda_low));
   // accumulate pulses so none is lost between status reads; cleared in reset so the
   // unknown value the outputs hold before the first clock edge cannot stick in the record
   always @(posedge clk_in) meas_seen <= resetn_in ? (meas_seen | meas) : 3'h0;
   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rchk(input [7:0] p, input [7:0] exp);
      begin
         host.rd(adr, p, v, ok);
         chk(v, exp);
      end
   endtask
   // poll status until the counter leaves the saved value or the error shows, then compare
   task pchk(input [7:0] saved, input [7:0] exp);
      integer n;
      begin
         n = 0;
         host.rd(adr, 8'h11, v, ok);
         while (v[3:0] == saved[3:0] && !v[4] && n < 8) begin
            n = n + 1;
            host.rd(adr, 8'h11, v, ok);
         end
         chk(v, exp);
      end
   endtask
   task wreg(input [7:0] p, input [7:0] d0, input [7:0] d1, input integer n);
      host.wr(adr, p, d0, d1, n, ok);
   endtask
   task wrap_up;
      begin
         $display("compares %0d error_cnt %0d", compares, error_cnt);
         if (error_cnt == 0 && compares > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // watchdog sized well above the whole command sequence
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      $display("MISMATCH t=%0t run did not finish", $time);
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      rchk(8'h11, 8'h2F);
      rchk(8'h10, 8'h00);
      rchk(8'h0A, 8'h00);
      rchk(8'h0B, 8'h00);
      rchk(8'h05, 8'h00);
      wreg(8'h11, 8'hFF, 8'h00, 1);
      rchk(8'h11, 8'h2F);
      $display("test reset values done");
      wreg(8'h0A, 8'hA5, 8'h95, 2);
      pchk(8'h2F, 8'h20);
      rchk(8'h10, 8'hA5);
      wreg(8'h0A, 8'h3C, 8'h81, 2);
      rchk(8'h11, 8'h21);
      chk(chan, 8'h3C);
      wreg(8'h0B, 8'h55, 8'h00, 1);
      rchk(8'h11, 8'h22);
      rchk(8'h10, 8'hA5);
      $display("test parameter access done");
      for (i = 0; i < 3; i = i + 1) begin
         wreg(8'h0B, 8'h11 + i[7:0], 8'h00, 1);
         rchk(8'h11, 8'h23 + i[7:0]);
         chk({5'h00, meas_seen}, (8'h02 << i) - 8'h01);
      end
      $display("test measurement commands done");
      wreg(8'h0B, 8'h6E, 8'h00, 1);
      pchk(8'h25, 8'h35);
      wreg(8'h0B, 8'h05, 8'h00, 1);
      rchk(8'h11, 8'h35);
      wreg(8'h0B, 8'h00, 8'h00, 1);
      rchk(8'h11, 8'h20);
      $display("test error recovery done");
      wreg(8'h0A, 8'hAB, 8'h80, 2);
      rchk(8'h11, 8'h21);
      wreg(8'h0B, 8'h02, 8'h00, 1);
      adr = 7'h2B;
      rchk(8'h11, 8'h22);
      host.rd(7'h2A, 8'h11, v, ok);
      chk({7'h00, ok}, 8'h00);
      $display("test address change done");
      wreg(8'h0B, 8'h01, 8'h00, 1);
      host.hp(200);
      adr = 7'h2A;
      rchk(8'h11, 8'h2F);
      rchk(8'h10, 8'h00);
      chk(chan, 8'h00);
      wreg(8'h0B, 8'h55, 8'h00, 1);
      rchk(8'h11, 8'h20);
      rchk(8'h10, 8'h00);
      $display("test soft reset done");
      wrap_up;
   end
endmodule
